// ---- rtl/fbp_pkg.sv ----
// shared constants and types for the flash erase and protection block
package fbp_pkg;
    localparam int FLASH_BYTES = 8192;
    localparam int UNIT_BYTES = 1024;
    localparam int REGION_BYTES = 2048;
    localparam int WORD_BYTES = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int WORDS = FLASH_BYTES / WORD_BYTES;
    localparam int IDX_W = $clog2(WORDS);
    localparam int UNITS = FLASH_BYTES / UNIT_BYTES;
    localparam int UNIT_W = $clog2(UNITS);
    localparam int UNIT_WORDS = UNIT_BYTES / WORD_BYTES;
    localparam int CNT_W = $clog2(UNIT_WORDS);
    localparam int REGIONS = FLASH_BYTES / REGION_BYTES;
    localparam int REG_W = $clog2(REGIONS);
    localparam int MODE_W = 2;
    localparam int BYTE_LSB = $clog2(WORD_BYTES);
    localparam int REGION_LSB = $clog2(REGION_BYTES);
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] FLASH_LIMIT = 16'h2000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        FBP_OPEN = 2'h0,
        FBP_RDONLY = 2'h1,
        FBP_XONLY = 2'h2,
        FBP_XONLY_ALT = 2'h3
    } fbp_mode_e;

    typedef enum logic [1:0] {
        FBP_FETCH = 2'h0,
        FBP_DREAD = 2'h1,
        FBP_MODIFY = 2'h2
    } fbp_kind_e;

    typedef enum logic {
        FBP_IDLE = 1'b0,
        FBP_ERASE = 1'b1
    } fbp_state_e;
endpackage

// ---- rtl/fbp_guard.sv ----
// address range and region permission check for one access path
`timescale 1ns/10ps
`default_nettype none
module fbp_guard (
    input wire logic [fbp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fbp_pkg::REGIONS*fbp_pkg::MODE_W-1:0] mode_i,
    input wire fbp_pkg::fbp_kind_e kind_i,
    output logic in_range_o,
    output logic permit_o
);
    import fbp_pkg::*;

    logic [REG_W-1:0] region;
    fbp_mode_e mode;

    always_comb begin
        in_range_o = addr_i < FLASH_LIMIT;
        region = addr_i[REGION_LSB +: REG_W];
        mode = fbp_mode_e'(mode_i[MODE_W*region +: MODE_W]);
        case (kind_i)
            FBP_FETCH: permit_o = 1'b1;
            // both upper codes act as execute-only, the stricter reading
            FBP_DREAD: permit_o = (mode == FBP_OPEN) ||
                                  (mode == FBP_RDONLY);
            FBP_MODIFY: permit_o = (mode == FBP_OPEN);
            default: permit_o = 1'b0;
        endcase
        if (!in_range_o) begin
            permit_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fbp_flash_protect.sv ----
// flash array with per-unit erase and per-region access protection
//
// Summary of operation
// - array holds 8 KB; any access at or beyond that size is refused.
// - erase works on one 1 KB unit at a time, chosen independently.
// - every word of an erased unit reads back as all ones.
// - protection applies per 2 KB region, two adjacent units, each separate.
// - each region is open, read-only or execute-only by configuration.
// - read-only regions refuse every erase and program request.
// - execute-only regions also refuse every erase and program request.
// - execute-only regions answer instruction fetches only, never data reads.
`timescale 1ns/10ps
`default_nettype none
module fbp_flash_protect #(
    parameter int DATA_W = fbp_pkg::DATA_W,
    parameter int WORDS = fbp_pkg::WORDS
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [fbp_pkg::REGIONS*fbp_pkg::MODE_W-1:0] prot_mode_i,
    input wire logic fetch_req_i,
    input wire logic [fbp_pkg::ADDR_W-1:0] fetch_addr_i,
    output logic fetch_ack_o,
    output logic fetch_err_o,
    output logic [DATA_W-1:0] fetch_rdata_o,
    input wire logic data_req_i,
    input wire logic [fbp_pkg::ADDR_W-1:0] data_addr_i,
    output logic data_ack_o,
    output logic data_err_o,
    output logic [DATA_W-1:0] data_rdata_o,
    input wire logic prog_req_i,
    input wire logic [fbp_pkg::ADDR_W-1:0] prog_addr_i,
    input wire logic [DATA_W-1:0] prog_wdata_i,
    input wire logic erase_req_i,
    input wire logic [fbp_pkg::UNIT_W-1:0] erase_unit_i,
    output logic busy_o,
    output logic op_done_o,
    output logic op_err_o,
    input wire logic viol_clr_i,
    output logic viol_o
);
    import fbp_pkg::*;

    logic [DATA_W-1:0] mem_ff [WORDS];
    fbp_state_e state_ff, nxt_state;
    logic [UNIT_W-1:0] unit_ff, nxt_unit;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wr_en, wr_ok;
    logic [IDX_W-1:0] wr_idx;
    logic [DATA_W-1:0] wr_data;
    logic fetch_ack_ff, nxt_fetch_ack;
    logic fetch_err_ff, nxt_fetch_err;
    logic [DATA_W-1:0] fetch_rdata_ff, nxt_fetch_rdata;
    logic data_ack_ff, nxt_data_ack;
    logic data_err_ff, nxt_data_err;
    logic [DATA_W-1:0] data_rdata_ff, nxt_data_rdata;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic oerr_ff, nxt_oerr;
    logic viol_ff, nxt_viol;
    logic f_rng, f_ok, d_rng, d_ok, m_rng, m_ok;
    logic [ADDR_W-1:0] mod_addr;
    logic viol_set;

    function automatic logic [IDX_W-1:0] word_idx(
        input logic [ADDR_W-1:0] addr
    );
        word_idx = addr[BYTE_LSB +: IDX_W];
    endfunction

    function automatic logic [ADDR_W-1:0] unit_base(
        input logic [UNIT_W-1:0] unit
    );
        unit_base = ADDR_W'({unit, CNT_ZERO, {BYTE_LSB{1'b0}}});
    endfunction

    fbp_guard u_fetch_guard (
        .addr_i(fetch_addr_i),
        .mode_i(prot_mode_i),
        .kind_i(FBP_FETCH),
        .in_range_o(f_rng),
        .permit_o(f_ok)
    );

    fbp_guard u_data_guard (
        .addr_i(data_addr_i),
        .mode_i(prot_mode_i),
        .kind_i(FBP_DREAD),
        .in_range_o(d_rng),
        .permit_o(d_ok)
    );

    // erase is checked at its unit base, so the unit's region decides
    assign mod_addr = erase_req_i ? unit_base(erase_unit_i) : prog_addr_i;

    fbp_guard u_mod_guard (
        .addr_i(mod_addr),
        .mode_i(prot_mode_i),
        .kind_i(FBP_MODIFY),
        .in_range_o(m_rng),
        .permit_o(m_ok)
    );

    // read paths: one cycle to answer, refused reads return zero
    always_comb begin
        nxt_fetch_ack = fetch_req_i;
        nxt_fetch_err = fetch_req_i && !f_ok;
        nxt_fetch_rdata = fetch_rdata_ff;
        if (fetch_req_i) begin
            nxt_fetch_rdata = f_ok ? mem_ff[word_idx(fetch_addr_i)]
                                   : ZERO_WORD;
        end
        nxt_data_ack = data_req_i;
        nxt_data_err = data_req_i && !d_ok;
        nxt_data_rdata = data_rdata_ff;
        if (data_req_i) begin
            nxt_data_rdata = d_ok ? mem_ff[word_idx(data_addr_i)]
                                  : ZERO_WORD;
        end
    end

    // modify path: erase walks one word per cycle through its unit
    always_comb begin
        nxt_state = state_ff;
        nxt_unit = unit_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_oerr = 1'b0;
        wr_en = 1'b0;
        wr_idx = word_idx(prog_addr_i);
        wr_data = mem_ff[word_idx(prog_addr_i)] & prog_wdata_i;
        wr_ok = 1'b0;
        viol_set = 1'b0;
        case (state_ff)
            FBP_IDLE: begin
                // requests are taken only when idle; erase beats program
                if (erase_req_i || prog_req_i) begin
                    wr_ok = m_ok;
                    if (!m_ok) begin
                        nxt_oerr = 1'b1;
                        viol_set = m_rng;
                    end else if (erase_req_i) begin
                        nxt_state = FBP_ERASE;
                        nxt_unit = erase_unit_i;
                        nxt_cnt = CNT_ZERO;
                    end else begin
                        // program only clears bits, as flash cells do
                        wr_en = wr_ok;
                        nxt_done = 1'b1;
                    end
                end
            end
            FBP_ERASE: begin
                wr_en = 1'b1;
                wr_idx = {unit_ff, cnt_ff};
                wr_data = ERASED_WORD;
                nxt_cnt = CNT_W'(cnt_ff + CNT_ONE);
                if (cnt_ff == CNT_LAST) begin
                    nxt_state = FBP_IDLE;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_state = FBP_IDLE;
            end
        endcase
        nxt_busy = (nxt_state == FBP_ERASE);
        // a new violation in the clearing cycle still lands
        nxt_viol = (viol_ff && !viol_clr_i) || viol_set ||
                   (data_req_i && d_rng && !d_ok);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= FBP_IDLE;
            unit_ff <= '0;
            cnt_ff <= CNT_ZERO;
            fetch_ack_ff <= 1'b0;
            fetch_err_ff <= 1'b0;
            fetch_rdata_ff <= ZERO_WORD;
            data_ack_ff <= 1'b0;
            data_err_ff <= 1'b0;
            data_rdata_ff <= ZERO_WORD;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            oerr_ff <= 1'b0;
            viol_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            unit_ff <= nxt_unit;
            cnt_ff <= nxt_cnt;
            fetch_ack_ff <= nxt_fetch_ack;
            fetch_err_ff <= nxt_fetch_err;
            fetch_rdata_ff <= nxt_fetch_rdata;
            data_ack_ff <= nxt_data_ack;
            data_err_ff <= nxt_data_err;
            data_rdata_ff <= nxt_data_rdata;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            oerr_ff <= nxt_oerr;
            viol_ff <= nxt_viol;
        end
    end

    // array comes out of reset erased; only granted writes touch it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_ff[i] <= ERASED_WORD;
            end
        end else if (wr_en) begin
            mem_ff[wr_idx] <= wr_data;
        end
    end

    assign fetch_ack_o = fetch_ack_ff;
    assign fetch_err_o = fetch_err_ff;
    assign fetch_rdata_o = fetch_rdata_ff;
    assign data_ack_o = data_ack_ff;
    assign data_err_o = data_err_ff;
    assign data_rdata_o = data_rdata_ff;
    assign busy_o = busy_ff;
    assign op_done_o = done_ff;
    assign op_err_o = oerr_ff;
    assign viol_o = viol_ff;
endmodule
`default_nettype wire

// ---- sim/fbp_props.sv ----
// port assertions for the flash erase and protection block
`timescale 1ns/10ps
`default_nettype none
module fbp_props (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] prot_mode_i,
    input wire logic fetch_req_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic fetch_ack_o,
    input wire logic fetch_err_o,
    input wire logic data_req_i,
    input wire logic [15:0] data_addr_i,
    input wire logic data_err_o,
    input wire logic prog_req_i,
    input wire logic [15:0] prog_addr_i,
    input wire logic erase_req_i,
    input wire logic [2:0] erase_unit_i,
    input wire logic busy_o,
    input wire logic op_done_o,
    input wire logic op_err_o,
    input wire logic viol_clr_i,
    input wire logic viol_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    wire logic [1:0] d_md = prot_mode_i[{data_addr_i[12:11], 1'b0} +: 2];
    wire logic [1:0] p_md = prot_mode_i[{prog_addr_i[12:11], 1'b0} +: 2];
    wire logic [1:0] e_md = prot_mode_i[{erase_unit_i[2:1], 1'b0} +: 2];
    wire logic go = !busy_o && !erase_req_i && prog_req_i;
    wire logic prog_go = go && prog_addr_i[15:13] == 3'h0;
    wire logic erase_go = !busy_o && erase_req_i;
    // counts busy samples so the walk length is checked exactly
    always_comb begin
        nxt_cnt = busy_o ? cnt_ff + 9'h001 : 9'h000;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 9'h000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    a_fetch_range: assert property (
        fetch_req_i && fetch_addr_i[15:13] != 3'h0
        |=> fetch_ack_o && fetch_err_o) else $error("fetch beyond array");
    a_fetch_open: assert property (
        fetch_req_i && fetch_addr_i[15:13] == 3'h0
        |=> fetch_ack_o && !fetch_err_o) else $error("fetch refused");
    a_data_block: assert property (
        data_req_i && data_addr_i[15:13] == 3'h0
        && d_md[1] |=> data_err_o && viol_o) else $error("data read leaked");
    a_prog_block: assert property (prog_go && p_md != 2'h0
        |=> op_err_o && !op_done_o && viol_o) else $error("program allowed");
    a_erase_block: assert property (erase_go && e_md != 2'h0
        |=> op_err_o && !busy_o) else $error("erase allowed");
    a_erase_start: assert property (erase_go && e_md == 2'h0
        |=> busy_o && !op_err_o) else $error("erase not started");
    a_erase_len: assert property ($fell(busy_o)
        |-> cnt_ff == 9'h100 && op_done_o) else $error("erase walk length");
    a_viol_hold: assert property (viol_o && !viol_clr_i |=> viol_o)
        else $error("violation flag lost");
    c_erase: cover property ($fell(busy_o));
    c_viol: cover property ($rose(viol_o));
    c_prog: cover property (op_done_o && !busy_o);
endmodule
bind fbp_flash_protect fbp_props u_fbp_props (.clk_sys_i, .rst_n_i,
    .prot_mode_i, .fetch_req_i, .fetch_addr_i, .fetch_ack_o, .fetch_err_o,
    .data_req_i, .data_addr_i, .data_err_o, .prog_req_i, .prog_addr_i,
    .erase_req_i, .erase_unit_i, .busy_o, .op_done_o, .op_err_o,
    .viol_clr_i, .viol_o);
`default_nettype wire

// ---- sim/fbp_host.sv ----
// bus master model issuing instruction fetches and data reads
`timescale 1ns/10ps
`default_nettype none
module fbp_host (
    input wire logic clk_sys_i,
    output logic fetch_req_o = 1'b0,
    output logic [15:0] fetch_addr_o = 16'h0000,
    output logic data_req_o = 1'b0,
    output logic [15:0] data_addr_o = 16'h0000
);
    task automatic rd(input logic dbus, input logic [15:0] a);
        @(negedge clk_sys_i);
        if (dbus) begin
            data_req_o = 1'b1;
            data_addr_o = a;
        end else begin
            fetch_req_o = 1'b1;
            fetch_addr_o = a;
        end
        @(negedge clk_sys_i);
        fetch_req_o = 1'b0;
        data_req_o = 1'b0;
        // released address lines must not keep looking valid
        fetch_addr_o = ~fetch_addr_o;
        data_addr_o = ~data_addr_o;
    endtask
endmodule
`default_nettype wire

// ---- sim/fbp_flash_protect_test.sv ----
// self-checking bench for the flash erase and protection block
`timescale 1ns/10ps
`default_nettype none
module fbp_flash_protect_test;
    import fbp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] prot_mode_i = 8'h00;
    logic prog_req_i = 1'b0;
    logic erase_req_i = 1'b0;
    logic viol_clr_i = 1'b0;
    logic [15:0] prog_addr_i = 16'h0000;
    logic [31:0] prog_wdata_i = 32'h0000_0000;
    logic [2:0] erase_unit_i = 3'h0;
    wire logic fetch_req_i, data_req_i, fetch_ack_o, fetch_err_o, data_ack_o;
    wire logic data_err_o, busy_o, op_done_o, op_err_o, viol_o;
    wire logic [15:0] fetch_addr_i, data_addr_i;
    wire logic [31:0] fetch_rdata_o, data_rdata_o;
    logic [31:0] mem [WORDS];
    logic [32:0] fq[$], dq[$];
    logic [1:0] oq[$];
    logic [15:0] a;
    logic [32:0] exp_v;
    int n_mismatch = 0;
    int total_checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    fbp_host u_fbp_host (.clk_sys_i, .fetch_req_o(fetch_req_i),
        .fetch_addr_o(fetch_addr_i), .data_req_o(data_req_i),
        .data_addr_o(data_addr_i));
    fbp_flash_protect u_fbp_flash_protect (.clk_sys_i, .rst_n_i, .prot_mode_i,
        .fetch_req_i, .fetch_addr_i, .fetch_ack_o, .fetch_err_o, .fetch_rdata_o,
        .data_req_i, .data_addr_i, .data_ack_o, .data_err_o, .data_rdata_o,
        .prog_req_i, .prog_addr_i, .prog_wdata_i, .erase_req_i, .erase_unit_i,
        .busy_o, .op_done_o, .op_err_o, .viol_clr_i, .viol_o);
    task automatic chk(input string nm, input logic [32:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic dbus, input logic [15:0] ad);
        logic [32:0] e;
        e = {1'b0, mem[ad[12:2]]};
        if (ad >= FLASH_LIMIT ||
            (dbus && prot_mode_i[{ad[12:11], 1'b0} +: 2] > 2'h1))
            e = {1'b1, ZERO_WORD};
        if (dbus) dq.push_back(e);
        else fq.push_back(e);
        u_fbp_host.rd(dbus, ad);
    endtask
    task automatic modify(input logic er, input logic [15:0] ad,
                          input logic [31:0] w);
        if (ad >= FLASH_LIMIT || prot_mode_i[{ad[12:11], 1'b0} +: 2] != 2'h0)
            oq.push_back(2'h1);
        else begin
            oq.push_back(2'h2);
            for (int i = 0; i < UNIT_WORDS; i++)
                if (er) mem[{ad[12:10], 8'(i)}] = ERASED_WORD;
            if (!er) mem[ad[12:2]] &= w;
        end
        @(negedge clk_sys_i);
        {erase_req_i, prog_req_i} = {er, !er};
        {prog_addr_i, prog_wdata_i, erase_unit_i} = {ad, w, ad[12:10]};
        @(negedge clk_sys_i);
        {erase_req_i, prog_req_i} = 2'h0;
        repeat (300) if (busy_o === 1'b1) @(negedge clk_sys_i);
    endtask
    always @(negedge clk_sys_i) begin
        if (fetch_ack_o === 1'b1) begin
            exp_v = fq.size() ? fq.pop_front() : 'x;
            chk("fetch", {fetch_err_o, fetch_rdata_o}, exp_v);
        end
        if (data_ack_o === 1'b1) begin
            exp_v = dq.size() ? dq.pop_front() : 'x;
            chk("data", {data_err_o, data_rdata_o}, exp_v);
        end
        if (op_done_o === 1'b1 || op_err_o === 1'b1) begin
            exp_v = oq.size() ? oq.pop_front() : 'x;
            chk("op", {op_done_o, op_err_o}, exp_v);
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(70875));
        foreach (mem[i]) mem[i] = ERASED_WORD;
        repeat (12) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        chk("viol", viol_o, 1'b0);
        for (int i = 0; i < 40; i++) begin
            a = 16'($urandom_range(0, 16'h1fff)) & 16'hfffc;
            modify(1'b0, a, $urandom);
            rd(i[0], a);
            rd(!i[0], a | 16'h2000);
        end
        modify(1'b0, 16'h2000, 32'h0000_0000);
        chk("viol", viol_o, 1'b0);
        $display("test open array done");
        modify(1'b0, 16'h0804, 32'h1234_5678);
        // modes 1, 2, 3 refuse; open last so the erase really runs
        for (int m = 1; m < 5; m++) begin
            prot_mode_i = {4'h0, 2'(m), 2'h0};
            modify(1'b0, 16'h0804, 32'h0000_0000);
            modify(1'b1, 16'h0800, 32'h0000_0000);
            rd(1'b0, 16'h0804);
            rd(1'b1, 16'h0804);
            // neighbouring regions stay open while region one is locked
            modify(1'b0, 16'h1004, $urandom);
            rd(1'b1, 16'h0004);
            chk("viol", viol_o, 2'(m) != 2'h0);
            @(negedge clk_sys_i);
            viol_clr_i = 1'b1;
            @(negedge clk_sys_i);
            viol_clr_i = 1'b0;
            chk("viol", viol_o, 1'b0);
        end
        $display("test protection modes done");
        chk("left", 33'(fq.size() + dq.size() + oq.size()), 33'h0);
        final_report();
    end
endmodule
`default_nettype wire
